// ### flc_cfg.svh
// address map, field positions and reset values of the lock configuration block
`ifndef FLC_CFG_SVH
`define FLC_CFG_SVH
`define FLC_SPACE_BIT  22
`define FLC_ADDR_MAKER 28'hFBC_0000
`define FLC_ADDR_GPI   28'hFBC_0100
`define FLC_LOCK_TOP   8'hFB
`define FLC_LOCK_LOW   12'h002
`define FLC_WL         0
`define FLC_LD         1
`define FLC_RL         2
`define FLC_LOCK_RST   3'h1
`define FLC_NREG       64
`define FLC_TOP_BLK    4'hF
`define FLC_SECT_B0    4'h0
`define FLC_SECT_B1    4'hE
`define FLC_SECT_B2    4'hF
`define FLC_GPI_W      5
`define FLC_ZERO8      8'h00
`endif

// ### flc_host_model.sv
// host model issuing single configuration cycles
`timescale 1ns/1ps
module flc_host_model
  import flc_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       bus_ack_q,
  input  wire logic [7:0] bus_rdata_q,
  output flc_bus_req_t    bus
);
  initial bus = '0;
  // one request pulse, answer taken in the ack cycle
  task automatic access(input logic we, input logic [27:0] a, input logic [7:0] wd,
                        output logic [7:0] rd, output logic ak);
    @(negedge clock);
    bus = '{req: 1'h1, we: we, addr: a, wdata: wd};
    @(negedge clock);
    ak = bus_ack_q;
    rd = bus_rdata_q;
    bus.req = 1'h0;
  endtask
endmodule

// ### flc_lock_regs.sv
// per block and sector lock registers, input pin and maker registers
`timescale 1ns/1ps
`include "flc_cfg.svh"
//
// Overview of operation
// R1: registers reachable only in host-interface mode
// R2: single read or write, space bit cleared
// R3: host prepends F nibble to address
// R4: one lock register per block and sector
// R5: lock registers readable and writable
// R6: write lock blocks program/erase, flags error
// R7: write lock clear lets program/erase run
// R8: write lock set after any reset
// R9: read lock makes array reads return zero
// R10: read lock cleared after any reset
// R11: lock-down freezes all three lock bits
// R12: lock-down cleared only by resets
// R13: unfrozen register accepts lock bit changes
// R14: bits seven to three reserved
// R15: top-block-lock low protects block fifteen
// R16: write-protect low protects blocks zero-fourteen
// R17: input register bits mirror five pins
// R18: input register read-only at its address
// R19: maker register read-only, fixed code
// R20: protect error flag sticky until cleared
// R21: writes to read-only registers ignored
// R22: host holds input pins stable during read
// R23: reserved bits read zero, writes ignored
module flc_lock_regs
  import flc_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE = 8'h5A  // arbitrary value
) (
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  input  wire logic                 interface_reset_n,
  input  wire logic                 cpu_init_n,
  input  wire logic                 lpc_mode,
  input  wire flc_bus_req_t         bus,
  output logic                      bus_ack_q,
  output logic [7:0]                bus_rdata_q,
  input  wire logic [`FLC_GPI_W-1:0] gp_input,
  input  wire logic                 top_block_lock_n,
  input  wire logic                 write_protect_n,
  input  wire flc_loc_t             pe,
  output logic                      pe_go_q,
  output logic                      pe_reject_q,
  output logic                      protect_error_flag_q,
  input  wire logic                 clear_status,
  input  wire flc_loc_t             ard,
  input  wire logic [7:0]           ard_data,
  output logic                      ard_valid_q,
  output logic [7:0]                ard_data_q
);

  // ****************************************
  // index and protection helpers
  // ****************************************
  logic [2:0] lock_q [`FLC_NREG];
  logic       rst_any;
  logic       cfg_hit;
  logic       lock_hit;
  logic [5:0] bus_idx;
  logic [5:0] pe_idx;
  logic [5:0] ard_idx;
  logic       pe_prot;

  function automatic logic [5:0] lock_idx(input logic [3:0] blk, input logic [3:0] sec);
    if (blk == `FLC_SECT_B0) begin
      return {2'b01, sec};
    end else if (blk == `FLC_SECT_B1) begin
      return {2'b10, sec};
    end else if (blk == `FLC_SECT_B2) begin
      return {2'b11, sec};
    end
    return {2'b00, blk};
  endfunction

  function automatic logic pin_prot(input logic [3:0] blk, input logic top_lock_n, input logic wp_n);
    if (blk == `FLC_TOP_BLK) begin
      return !top_lock_n;  // R15
    end
    return !wp_n;  // R16
  endfunction

  assign rst_any  = !rst_n || !interface_reset_n || !cpu_init_n;
  // R1 R2 R3
  assign cfg_hit  = lpc_mode && !bus.addr[`FLC_SPACE_BIT];
  assign lock_hit = cfg_hit && (bus.addr[27:20] == `FLC_LOCK_TOP) && (bus.addr[11:0] == `FLC_LOCK_LOW);
  assign bus_idx  = lock_idx(bus.addr[19:16], bus.addr[15:12]);
  assign pe_idx   = lock_idx(pe.blk, pe.sec);
  assign ard_idx  = lock_idx(ard.blk, ard.sec);
  assign pe_prot  = lock_q[pe_idx][`FLC_WL] || pin_prot(pe.blk, top_block_lock_n, write_protect_n);

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst_any);

  // ****************************************
  // lock register storage
  // ****************************************
  always_ff @(posedge clock) begin
    if (rst_any) begin
      for (int i = 0; i < `FLC_NREG; i++) begin
        lock_q[i] <= `FLC_LOCK_RST;  // R8 R10 R12
      end
    end else if (bus.req && bus.we && lock_hit && !lock_q[bus_idx][`FLC_LD]) begin  // R11
      lock_q[bus_idx] <= bus.wdata[2:0];  // R5 R13 R14 R23
    end
  end

  frozen_hold_a: assert property (  // R11
    (bus.req && bus.we && lock_hit && lock_q[bus_idx][`FLC_LD])
      |=> lock_q[$past(bus_idx)] == $past(lock_q[bus_idx]))
    else $error("frozen lock register changed");

  open_write_a: assert property (  // R13
    (bus.req && bus.we && lock_hit && !lock_q[bus_idx][`FLC_LD])
      |=> lock_q[$past(bus_idx)] == $past(bus.wdata[2:0]))
    else $error("unfrozen lock write not taken");

  reset_locks_a: assert property (  // R8 R10 R12
    disable iff (1'b0)
      rst_any |=> lock_q[bus_idx] == `FLC_LOCK_RST)
    else $error("lock register not reset");

  other_write_a: assert property (  // R21
    (bus.req && bus.we && cfg_hit && !lock_hit)
      |=> lock_q[$past(bus_idx)] == $past(lock_q[bus_idx]))
    else $error("read-only write changed a lock");

  outside_write_a: assert property (  // R1
    (bus.req && bus.we && !cfg_hit)
      |=> lock_q[$past(bus_idx)] == $past(lock_q[bus_idx]))
    else $error("write outside space changed a lock");

  // ****************************************
  // configuration read answer
  // ****************************************
  always_ff @(posedge clock) begin
    if (rst_any) begin
      bus_ack_q   <= 1'b0;
      bus_rdata_q <= `FLC_ZERO8;
    end else begin
      bus_ack_q <= bus.req && cfg_hit;  // R2
      if (bus.req && cfg_hit && !bus.we) begin
        if (lock_hit) begin
          bus_rdata_q <= {5'h00, lock_q[bus_idx]};  // R4 R5 R23
        end else if (bus.addr == `FLC_ADDR_GPI) begin
          bus_rdata_q <= {3'h0, gp_input};  // R17 R18 R22
        end else if (bus.addr == `FLC_ADDR_MAKER) begin
          bus_rdata_q <= MAKER_CODE;  // R19
        end else begin
          bus_rdata_q <= `FLC_ZERO8;
        end
      end
      // R21: writes elsewhere in the space leave nothing behind
    end
  end

  gpi_read_a: assert property (  // R17
    (bus.req && !bus.we && cfg_hit && bus.addr == `FLC_ADDR_GPI)
      |=> bus_ack_q && bus_rdata_q == {3'h0, $past(gp_input)})
    else $error("input register mismatch");

  maker_read_a: assert property (  // R19
    (bus.req && !bus.we && cfg_hit && bus.addr == `FLC_ADDR_MAKER) |=> bus_rdata_q == MAKER_CODE)
    else $error("maker code mismatch");

  no_cfg_a: assert property (  // R1
    (!lpc_mode || bus.addr[`FLC_SPACE_BIT]) |=> !bus_ack_q)
    else $error("config answered outside space");

  ack_given_a: assert property (  // R2
    (bus.req && cfg_hit)
      |=> bus_ack_q)
    else $error("config request not answered");

  ack_only_a: assert property (  // R2
    !(bus.req && cfg_hit)
      |=> !bus_ack_q)
    else $error("answer without request");

  lock_read_a: assert property (  // R5 R23
    (bus.req && !bus.we && lock_hit)
      |=> bus_rdata_q == {5'h00, $past(lock_q[bus_idx])})
    else $error("lock register read mismatch");

  reserved_zero_a: assert property (  // R14 R23
    (bus.req && !bus.we && cfg_hit && bus.addr != `FLC_ADDR_MAKER)
      |=> bus_rdata_q[7:5] == 3'h0)
    else $error("reserved bits not zero");

  rdata_hold_a: assert property (  // R2
    !(bus.req && !bus.we && cfg_hit)
      |=> $stable(bus_rdata_q))
    else $error("read data changed without read");

  // ****************************************
  // program and erase gate
  // ****************************************
  always_ff @(posedge clock) begin
    if (rst_any) begin
      pe_go_q     <= 1'b0;
      pe_reject_q <= 1'b0;
    end else begin
      pe_go_q     <= pe.req && !pe_prot;  // R7
      pe_reject_q <= pe.req && pe_prot;  // R6
    end
  end

  reject_flag_a: assert property (  // R6
    (pe.req && lock_q[pe_idx][`FLC_WL]) |=> pe_reject_q && !pe_go_q && protect_error_flag_q)
    else $error("locked block not rejected");

  go_open_a: assert property (  // R7
    (pe.req && !lock_q[pe_idx][`FLC_WL] && top_block_lock_n && write_protect_n) |=> pe_go_q)
    else $error("open block not executed");

  top_pin_a: assert property (  // R15
    (pe.req && pe.blk == `FLC_TOP_BLK && !top_block_lock_n) |=> !pe_go_q)
    else $error("top block pin ignored");

  main_pin_a: assert property (  // R16
    (pe.req && pe.blk != `FLC_TOP_BLK && !write_protect_n) |=> !pe_go_q)
    else $error("write protect pin ignored");

  one_answer_a: assert property (  // R6 R7
    pe.req
      |=> pe_go_q != pe_reject_q)
    else $error("gate answer not exclusive");

  gate_quiet_a: assert property (  // R6 R7
    !pe.req
      |=> !pe_go_q && !pe_reject_q)
    else $error("gate answered without request");

  pin_reject_a: assert property (  // R15 R16
    (pe.req && ((pe.blk == `FLC_TOP_BLK && !top_block_lock_n) || (pe.blk != `FLC_TOP_BLK && !write_protect_n)))
      |=> pe_reject_q)
    else $error("pin protected block not rejected");

  always_ff @(posedge clock) begin
    if (rst_any) begin
      protect_error_flag_q <= 1'b0;
    end else if (pe.req && pe_prot) begin
      protect_error_flag_q <= 1'b1;  // R20
    end else if (clear_status) begin
      protect_error_flag_q <= 1'b0;
    end
  end

  flag_sticky_a: assert property (  // R20
    (protect_error_flag_q && !clear_status) |=> protect_error_flag_q)
    else $error("protect flag lost");

  flag_set_a: assert property (  // R20
    (pe.req && pe_prot)
      |=> protect_error_flag_q)
    else $error("protect flag not set");

  flag_clear_a: assert property (  // R20
    (clear_status && !(pe.req && pe_prot))
      |=> !protect_error_flag_q)
    else $error("protect flag not cleared");

  flag_quiet_a: assert property (  // R20
    (!protect_error_flag_q && !(pe.req && pe_prot))
      |=> !protect_error_flag_q)
    else $error("protect flag set without cause");

  // ****************************************
  // array read gate
  // ****************************************
  always_ff @(posedge clock) begin
    if (rst_any) begin
      ard_valid_q <= 1'b0;
      ard_data_q  <= `FLC_ZERO8;
    end else begin
      ard_valid_q <= ard.req;
      if (ard.req) begin
        ard_data_q <= lock_q[ard_idx][`FLC_RL] ? `FLC_ZERO8 : ard_data;  // R9
      end
    end
  end

  read_zero_a: assert property (  // R9
    (ard.req && lock_q[ard_idx][`FLC_RL]) |=> ard_valid_q && ard_data_q == `FLC_ZERO8)
    else $error("read locked data leaked");

  read_open_a: assert property (  // R9 R10
    (ard.req && !lock_q[ard_idx][`FLC_RL])
      |=> ard_valid_q && ard_data_q == $past(ard_data))
    else $error("open read data lost");

  read_idle_a: assert property (  // R9
    !ard.req
      |=> !ard_valid_q)
    else $error("read valid without request");

  reset_outs_a: assert property (  // R20
    disable iff (1'b0)
      rst_any |=> !bus_ack_q && !pe_go_q && !pe_reject_q && !protect_error_flag_q && !ard_valid_q)
    else $error("outputs not cleared by reset");

endmodule

// ### flc_pkg.sv
// types shared by the lock configuration block
package flc_pkg;
  typedef struct packed {
    logic        req;
    logic        we;
    logic [27:0] addr;
    logic [7:0]  wdata;
  } flc_bus_req_t;
  typedef struct packed {
    logic       req;
    logic [3:0] blk;
    logic [3:0] sec;
  } flc_loc_t;
endpackage

// ### test_flc_lock_regs.sv
// self-checking bench for the lock configuration block
`timescale 1ns/1ps
`include "flc_cfg.svh"
module test_flc_lock_regs
  import flc_pkg::*;
();
  localparam logic [7:0] MAKER = 8'h3C; // arbitrary value
  logic         clock, rst_n, interface_reset_n, cpu_init_n, lpc_mode, ak;
  logic         top_block_lock_n, write_protect_n, clear_status;
  logic         bus_ack_q, pe_go_q, pe_reject_q, protect_error_flag_q, ard_valid_q;
  logic [4:0]   gp_input;
  logic [7:0]   bus_rdata_q, ard_data, ard_data_q, rd;
  flc_bus_req_t bus;
  flc_loc_t     pe, ard;
  int           bad_count, checks, cyc;
  flc_lock_regs #(.MAKER_CODE(MAKER)) i_flc_lock_regs (.clock(clock), .rst_n(rst_n),
    .interface_reset_n(interface_reset_n), .cpu_init_n(cpu_init_n), .lpc_mode(lpc_mode),
    .bus(bus), .bus_ack_q(bus_ack_q), .bus_rdata_q(bus_rdata_q), .gp_input(gp_input),
    .top_block_lock_n(top_block_lock_n), .write_protect_n(write_protect_n), .pe(pe),
    .pe_go_q(pe_go_q), .pe_reject_q(pe_reject_q), .protect_error_flag_q(protect_error_flag_q),
    .clear_status(clear_status), .ard(ard), .ard_data(ard_data), .ard_valid_q(ard_valid_q),
    .ard_data_q(ard_data_q));
  flc_host_model i_flc_host_model (.clock(clock), .bus_ack_q(bus_ack_q),
    .bus_rdata_q(bus_rdata_q), .bus(bus));
  // ****
  // helpers
  // ****
  initial begin
    clock = 1'h0;
    forever #25 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      summarize();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rw(input logic we, input logic [27:0] a, input logic [7:0] wd);
    i_flc_host_model.access(we, a, wd, rd, ak);
  endtask
  function automatic logic [27:0] la(input logic [3:0] b);
    return {8'hFB, b, 4'h0, 12'h002};
  endfunction
  task automatic gate(input logic [3:0] b, input logic [7:0] exp);
    @(negedge clock);
    pe = '{req: 1'h1, blk: b, sec: 4'h0};
    @(negedge clock);
    pe.req = 1'h0;
    chk({5'h00, pe_go_q, pe_reject_q, protect_error_flag_q}, exp);
  endtask
  task automatic aread(input logic [3:0] b);
    @(negedge clock);
    ard = '{req: 1'h1, blk: b, sec: 4'h0};
    @(negedge clock);
    ard.req = 1'h0;
  endtask
  task automatic summarize();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ****
  // tests
  // ****
  initial begin
    {rst_n, cyc, bad_count, checks, clear_status, pe, ard} = '0;
    {interface_reset_n, cpu_init_n, lpc_mode, top_block_lock_n, write_protect_n} = 5'h1F;
    gp_input = 5'h16;
    ard_data = 8'hA5;
    repeat (12) @(negedge clock);
    rst_n = 1'h1;
    rw(1'h0, la(4'h3), 8'h00);
    chk(rd, 8'h01);
    chk({7'h00, ak}, 8'h01);
    rw(1'h1, `FLC_ADDR_MAKER, 8'hFF);
    rw(1'h0, `FLC_ADDR_MAKER, 8'h00);
    chk(rd, MAKER);
    rw(1'h0, `FLC_ADDR_GPI, 8'h00);
    chk(rd, 8'h16);
    aread(4'h4);
    chk(ard_data_q, 8'hA5);
    chk({7'h00, ard_valid_q}, 8'h01);
    $display("reset values done");
    gate(4'h3, 8'h03);
    clear_status = 1'h1;
    gate(4'h3, 8'h03);
    @(negedge clock);
    clear_status = 1'h0;
    chk({7'h00, protect_error_flag_q}, 8'h00);
    rw(1'h1, la(4'h3), 8'hFC);
    rw(1'h0, la(4'h3), 8'h00);
    chk(rd, 8'h04);
    aread(4'h3);
    chk(ard_data_q, 8'h00);
    chk({7'h00, ard_valid_q}, 8'h01);
    gate(4'h3, 8'h04);
    write_protect_n = 1'h0;
    gate(4'h3, 8'h03);
    write_protect_n = 1'h1;
    top_block_lock_n = 1'h0;
    rw(1'h1, la(4'hF), 8'h00);
    gate(4'hF, 8'h03);
    top_block_lock_n = 1'h1;
    $display("protection done");
    for (int i = 0; i < 2; i++) begin
      rw(1'h1, la(4'h5), 8'h07);
      rw(1'h1, la(4'h5), 8'h00);
      rw(1'h0, la(4'h5), 8'h00);
      chk(rd, 8'h07);
      if (i == 0) begin
        interface_reset_n = 1'h0;
      end else begin
        cpu_init_n = 1'h0;
      end
      @(negedge clock);
      interface_reset_n = 1'h1;
      cpu_init_n = 1'h1;
      rw(1'h0, la(4'h5), 8'h00);
      chk(rd, 8'h01);
    end
    lpc_mode = 1'h0;
    rw(1'h0, `FLC_ADDR_MAKER, 8'h00);
    chk({7'h00, ak}, 8'h00);
    rw(1'h1, la(4'h5), 8'h06);
    lpc_mode = 1'h1;
    rw(1'h0, la(4'h5), 8'h00);
    chk(rd, 8'h01);
    rw(1'h0, 28'hFFC_0000, 8'h00);
    chk({7'h00, ak}, 8'h00);
    $display("lock-down and refusals done");
    summarize();
  end
endmodule
